// *** hdl/bte_pkg.sv ***
// Purpose: constants and carriers for the block transfer engine
// Assumes: 32-bit register bus, lines hold bits 32..63 of a 64-bit word
// Notes: line bit k sits on bus bit 63-k
package bte_pkg;
  localparam int unsigned BTE_AW = 10;
  // Byte address is {block, line, 2'b00}
  localparam logic [2:0] BTE_BLK_PAR = 3'h4;
  localparam logic [2:0] BTE_BLK_XCH = 3'h5;
  localparam logic [2:0] BTE_BLK_CHMAX = 3'h3;
  localparam logic [4:0] BTE_LN_SRC = 5'h00;
  localparam logic [4:0] BTE_LN_DST = 5'h01;
  localparam logic [4:0] BTE_LN_SIZE = 5'h02;
  localparam logic [4:0] BTE_LN_STAT = 5'h03;
  localparam logic [4:0] BTE_LN_PFO = 5'h00;
  localparam logic [4:0] BTE_LN_PARITY_REQUEST_INHIBIT = 5'h01;
  localparam logic [4:0] BTE_LN_CMPL = 5'h02;
  localparam logic [4:0] BTE_LN_SENDER_PARITY_FAIL = 5'h00;
  localparam logic [4:0] BTE_LN_UPF = 5'h01;
  // Status line fields
  localparam int unsigned BTE_ST_TIP = 3;
  localparam int unsigned BTE_ST_CMPL = 2;
  localparam int unsigned BTE_ST_PAR = 1;
  localparam logic [3:0] BTE_ST_RST = 4'h0;
  // Address line fields
  localparam int unsigned BTE_SA_NULL = 22;
  localparam logic [3:0] BTE_NULL_UNIT = 4'h9;
  localparam logic [23:0] BTE_MIN_MASK = 24'h00000F;
  localparam logic [15:0] BTE_N_STEP = 16'h0002;
  localparam logic [15:0] BTE_N_LAST = 16'h0000;
  localparam logic [1:0] BTE_OKAY = 2'h0;
  localparam logic [1:0] BTE_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    BTE_IDLE = 3'b001,
    BTE_READ = 3'b010,
    BTE_WRITE = 3'b100
  } bte_state_e;

  // Request to the exchange, held until acknowledged
  typedef struct packed {
    logic valid;
    logic write;
    logic [27:0] addr;
    logic [63:0] data;
  } bte_xreq_s;

  // Answer from the exchange; pf flags a parity fault on the transfer
  typedef struct packed {
    logic ack;
    logic pf;
    logic [63:0] data;
  } bte_xrsp_s;
endpackage

// *** hdl/bte_top.sv ***
// Purpose: four-channel block transfer engine with parity lines
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: one 64-bit word per turn, channels served round-robin
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Four channels share engine in equal turns
// - Word read into buffer, then written
// - Each block spans thirty-two 64-bit lines
// - Source aligned to power-of-two size, min 16
// - Source bit 41 plus unit 9 writes zeros
// - Destination aligned like the source
// - Last word first, count down by two
// - Size field names the interrupted unit
// - Bit 60 starts, aborts, cleared at end
// - Bit 61 set at end, drives interrupt
// - Bit 62 marks parity-aborted transfer
// - Incoming address parity fault flagged, read clears
// - Inhibit bit stops requests on broadcast fault
// - Summary shows channel completion bits 56-59
// - Sender parity faults marked per unit
// - Reading sender line clears it and summary
// - Sender bit 51 marks address/control parity
// - Unit line bit 51 mirrors any sender bit
// - Unit bits follow each unit's own flag
// - New unit fault broadcast to all units
// - Exchange lines decoded as block five
module bte_top
  import bte_pkg::*;
#(
  parameter int unsigned N_CH = 4,
  parameter int unsigned OWN_UNIT = 0
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [BTE_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [BTE_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output bte_xreq_s xreq_o,
  input wire bte_xrsp_s xrsp_i,
  input wire logic addr_pf_i,
  input wire logic [0:11] sender_pf_i,
  input wire logic cap_pf_i,
  input wire logic [0:11] unit_pf_i,
  input wire logic pf_bcast_i,
  input wire logic pint_inhibit_i,
  output logic pfo_o,
  output logic pf_bcast_o,
  output logic [15:0] irq_unit_o
);

  if (N_CH != 4 || OWN_UNIT > 11)
  begin : g_bad_param
    $error("N_CH must be 4 and OWN_UNIT at most 11");
  end

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction

  // Smallest 2^k-1 covering N+1 words, never below 15
  function automatic logic [23:0] align_mask(input logic [15:0] n);
    logic [23:0] m;
    m = {8'h00, n} + 24'h000001;
    for (int s = 1; s < 24; s = s * 2)
      m = m | (m >> s);
    return m | BTE_MIN_MASK;
  endfunction

  logic [31:0] src_reg [N_CH];
  logic [31:0] dst_reg [N_CH];
  logic [19:0] size_reg [N_CH];
  logic [3:0] stat_reg [N_CH];
  logic [23:0] mask_reg [N_CH];
  logic pfo_reg, parity_request_inhibit_reg, stall_reg, bcast_reg;
  logic [12:0] sender_parity_fail_reg, upf_reg;
  logic [15:0] irq_reg, irq_next;
  bte_state_e state_reg;
  logic [1:0] cur_reg, rr_reg, pick_w;
  logic pick_ok_w;
  logic [63:0] buf_reg;
  bte_xreq_s xreq_reg;
  logic wr_rdy_reg, bvalid_reg, rd_rdy_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, rmux_w;
  logic [N_CH-1:0] eng_step, eng_done, eng_perr, cmpl_w;

  ////////////////////////////////////////////////////////////////////////
  // Register bus decode
  wire wr_fire = wr_rdy_reg & s_axi_awvalid_i & s_axi_wvalid_i;
  wire rd_fire = rd_rdy_reg & s_axi_arvalid_i;
  wire [2:0] wblk = s_axi_awaddr_i[9:7];
  wire [4:0] wline = s_axi_awaddr_i[6:2];
  wire [2:0] rblk = s_axi_araddr_i[9:7];
  wire [4:0] rline = s_axi_araddr_i[6:2];
  wire [1:0] rch = rblk[1:0];
  wire w_ok = (wblk <= BTE_BLK_CHMAX) ? (wline <= BTE_LN_STAT) :
              (wblk == BTE_BLK_PAR) ? (wline <= BTE_LN_CMPL) :
              (wblk == BTE_BLK_XCH) && (wline <= BTE_LN_UPF);
  wire r_ok = (rblk <= BTE_BLK_CHMAX) ? (rline <= BTE_LN_STAT) :
              (rblk == BTE_BLK_PAR) ? (rline <= BTE_LN_CMPL) :
              (rblk == BTE_BLK_XCH) && (rline <= BTE_LN_UPF);
  wire par_rd = rd_fire & (rblk == BTE_BLK_PAR);
  // exchange lines live in block five
  wire xch_rd = rd_fire & (rblk == BTE_BLK_XCH);
  wire pfo_rd = par_rd & (rline == BTE_LN_PFO);
  wire sender_parity_fail_rd = xch_rd & (rline == BTE_LN_SENDER_PARITY_FAIL);
  wire parity_request_inhibit_we = wr_fire & (wblk == BTE_BLK_PAR) & (wline == BTE_LN_PARITY_REQUEST_INHIBIT);
  wire [31:0] parity_request_inhibit_m = merge({31'h0, parity_request_inhibit_reg}, s_axi_wdata_i,
                             s_axi_wstrb_i);
  wire [31:0] ch_rd = (rline == BTE_LN_SRC) ? src_reg[rch] :
                      (rline == BTE_LN_DST) ? dst_reg[rch] :
                      (rline == BTE_LN_SIZE) ? {12'h000, size_reg[rch]} :
                      {28'h0, stat_reg[rch]};
  // summary of completion bits, channel 0 on bit 56
  wire [31:0] par_rd_w = (rline == BTE_LN_PFO) ? {31'h0, pfo_reg} :
                         (rline == BTE_LN_PARITY_REQUEST_INHIBIT) ? {31'h0, parity_request_inhibit_reg} :
                         {24'h0, cmpl_w, 4'h0};
  wire [31:0] xch_rd_w = (rline == BTE_LN_SENDER_PARITY_FAIL) ? {19'h0, sender_parity_fail_reg} :
                         {19'h0, upf_reg};
  assign rmux_w = !r_ok ? 32'h0 :
                  (rblk <= BTE_BLK_CHMAX) ? ch_rd :
                  (rblk == BTE_BLK_PAR) ? par_rd_w : xch_rd_w;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_rdy_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= BTE_OKAY;
      rd_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= BTE_OKAY;
      rdata_reg <= 32'h0;
    end
    else
    begin
      wr_rdy_reg <= ~wr_rdy_reg & ~bvalid_reg & s_axi_awvalid_i &
                    s_axi_wvalid_i;
      rd_rdy_reg <= ~rd_rdy_reg & ~rvalid_reg & s_axi_arvalid_i;
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= w_ok ? BTE_OKAY : BTE_SLVERR;
      end
      else if (s_axi_bready_i)
        bvalid_reg <= 1'b0;
      if (rd_fire)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rmux_w;
        rresp_reg <= r_ok ? BTE_OKAY : BTE_SLVERR;
      end
      else if (s_axi_rready_i)
        rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel control lines
  for (genvar c = 0; c < N_CH; c++)
  begin : g_ch
    wire we = wr_fire & (wblk == 3'(c));
    wire [31:0] sz_m = merge({12'h0, size_reg[c]}, s_axi_wdata_i,
                             s_axi_wstrb_i);
    wire [31:0] st_m = merge({28'h0, stat_reg[c]}, s_axi_wdata_i,
                             s_axi_wstrb_i);
    wire st_we = we & (wline == BTE_LN_STAT);
    wire start = st_we & st_m[BTE_ST_TIP] & ~stat_reg[c][BTE_ST_TIP];
    logic [3:0] st_next;
    assign cmpl_w[N_CH-1-c] = stat_reg[c][BTE_ST_CMPL];
    always_comb
    begin
      st_next = st_we ? st_m[3:0] : stat_reg[c];
      // abort bits change in one update
      if (eng_done[c])
      begin
        st_next[BTE_ST_TIP] = 1'b0;
        st_next[BTE_ST_CMPL] = 1'b1;
        st_next[BTE_ST_PAR] = st_next[BTE_ST_PAR] | eng_perr[c];
      end
    end
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
      begin
        stat_reg[c] <= BTE_ST_RST;
        src_reg[c] <= 32'h0;
        dst_reg[c] <= 32'h0;
        size_reg[c] <= 20'h0;
        mask_reg[c] <= BTE_MIN_MASK;
      end
      else
      begin
        stat_reg[c] <= st_next;
        if (we & (wline == BTE_LN_SRC))
          src_reg[c] <= merge(src_reg[c], s_axi_wdata_i, s_axi_wstrb_i);
        if (we & (wline == BTE_LN_DST))
          dst_reg[c] <= merge(dst_reg[c], s_axi_wdata_i, s_axi_wstrb_i);
        // count steps down by two per word
        if (eng_step[c])
          size_reg[c][15:0] <= size_reg[c][15:0] - BTE_N_STEP;
        else if (we & (wline == BTE_LN_SIZE))
          size_reg[c] <= sz_m[19:0];
        // block mask fixed at start from initial size
        if (start)
          mask_reg[c] <= align_mask(size_reg[c][15:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer engine
  // rotating search from the channel after the last served
  always_comb
  begin
    pick_w = rr_reg;
    pick_ok_w = 1'b0;
    for (int k = N_CH - 1; k >= 0; k--)
      if (stat_reg[2'(rr_reg + 2'(k))][BTE_ST_TIP])
      begin
        pick_w = 2'(rr_reg + 2'(k));
        pick_ok_w = 1'b1;
      end
  end

  wire tip_cur = stat_reg[cur_reg][BTE_ST_TIP];
  wire [15:0] cur_n_w = size_reg[cur_reg][15:0];
  wire [31:0] src_cur = src_reg[cur_reg];
  wire [31:0] dst_cur = dst_reg[cur_reg];
  wire [23:0] msk_cur = mask_reg[cur_reg];
  // count is twice the words minus two, so last word sits at N
  // low bits forced to zero, offset N from block base
  wire [27:0] src_addr_w = {src_cur[27:24],
                            (src_cur[23:0] & ~msk_cur) | {8'h0, cur_n_w}};
  wire [27:0] dst_addr_w = {dst_cur[27:24],
                            (dst_cur[23:0] & ~msk_cur) | {8'h0, cur_n_w}};
  wire null_cur = src_cur[BTE_SA_NULL] & (src_cur[27:24] == BTE_NULL_UNIT);
  wire ack_w = xreq_reg.valid & xrsp_i.ack;
  wire cur_last_w = cur_n_w == BTE_N_LAST;
  wire [N_CH-1:0] cur_oh = 4'h1 << cur_reg;
  // data parity fault aborts the channel
  assign eng_perr = (ack_w & xrsp_i.pf) ? cur_oh : '0;
  assign eng_step = (ack_w & ~xrsp_i.pf & (state_reg == BTE_WRITE)) ?
                    cur_oh : '0;
  assign eng_done = eng_perr | (eng_step & {N_CH{cur_last_w}});

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= BTE_IDLE;
      cur_reg <= 2'h0;
      rr_reg <= 2'h0;
      buf_reg <= 64'h0;
      xreq_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        BTE_IDLE:
          if (pick_ok_w)
          begin
            cur_reg <= pick_w;
            rr_reg <= 2'(pick_w + 2'h1);
            state_reg <= BTE_READ;
          end
        // read into the holding buffer first
        BTE_READ:
          if (ack_w)
          begin
            xreq_reg.valid <= 1'b0;
            buf_reg <= xrsp_i.data;
            state_reg <= (xrsp_i.pf | ~tip_cur) ? BTE_IDLE : BTE_WRITE;
          end
          else if (!xreq_reg.valid)
          begin
            if (!tip_cur)
              state_reg <= BTE_IDLE;
            else if (null_cur)
            begin
              buf_reg <= 64'h0;
              state_reg <= BTE_WRITE;
            end
            else if (!stall_reg)
              xreq_reg <= '{1'b1, 1'b0, src_addr_w, 64'h0};
          end
        BTE_WRITE:
          if (ack_w)
          begin
            xreq_reg.valid <= 1'b0;
            state_reg <= BTE_IDLE;
          end
          else if (!xreq_reg.valid)
          begin
            if (!tip_cur)
              state_reg <= BTE_IDLE;
            else if (!stall_reg)
              xreq_reg <= '{1'b1, 1'b1, dst_addr_w, buf_reg};
          end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parity management and exchange lines
  wire [11:0] own_mark = pfo_reg ? (12'h800 >> OWN_UNIT) : 12'h000;
  // summary follows sender line; unit flags as held
  wire [12:0] upf_next = {|sender_parity_fail_reg, unit_pf_i | own_mark};

  // interrupt goes to the unit named in the size line
  always_comb
  begin
    irq_next = 16'h0;
    for (int c = 0; c < N_CH; c++)
      if (stat_reg[c][BTE_ST_CMPL])
        irq_next[size_reg[c][19:16]] = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pfo_reg <= 1'b0;
      parity_request_inhibit_reg <= 1'b0;
      stall_reg <= 1'b0;
      sender_parity_fail_reg <= 13'h0;
      upf_reg <= 13'h0;
      bcast_reg <= 1'b0;
      irq_reg <= 16'h0;
    end
    else
    begin
      // new fault wins over the clearing read
      pfo_reg <= addr_pf_i | (pfo_reg & ~pfo_rd);
      if (parity_request_inhibit_we)
        parity_request_inhibit_reg <= parity_request_inhibit_m[0];
      // held until software drops the inhibit bit
      stall_reg <= parity_request_inhibit_reg &
                   (stall_reg | (pf_bcast_i & ~pint_inhibit_i));
      sender_parity_fail_reg <= {cap_pf_i, sender_pf_i} |
                  (sender_parity_fail_reg & ~{13{sender_parity_fail_rd}});
      upf_reg <= upf_next;
      // any newly set unit bit is broadcast
      bcast_reg <= |(upf_next & ~upf_reg);
      irq_reg <= irq_next;
    end
  end

  assign s_axi_awready_o = wr_rdy_reg;
  assign s_axi_wready_o = wr_rdy_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = rd_rdy_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign xreq_o = xreq_reg;
  assign pfo_o = pfo_reg;
  assign pf_bcast_o = bcast_reg;
  assign irq_unit_o = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  wire [3:0] ui0_w = size_reg[0][19:16];
  wire st_we_any = wr_fire && wblk <= BTE_BLK_CHMAX &&
                   wline == BTE_LN_STAT;
  a_pfo_capture: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) addr_pf_i |=> pfo_reg)
    else $error("fault flag not set after address parity fault");
  a_done_status: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (|eng_done) && !st_we_any |=> !tip_cur && stat_reg[cur_reg][BTE_ST_CMPL])
    else $error("end of transfer left status wrong");
  a_parity_abort: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (|eng_perr) |=> stat_reg[cur_reg][BTE_ST_PAR] && !tip_cur)
    else $error("parity abort did not mark status");
  a_size_step: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (|eng_step) && !cur_last_w |=> cur_n_w == $past(cur_n_w) - 16'h0002)
    else $error("count did not drop by two");
  a_null_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    xreq_reg.valid && null_cur |-> xreq_reg.write && xreq_reg.data == 0)
    else $error("null transfer sent a read or nonzero data");
  a_stall_quiet: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    stall_reg && !xreq_reg.valid |=> !xreq_reg.valid)
    else $error("request issued while inhibited");
  a_word_offset: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    xreq_reg.valid |-> xreq_reg.addr[3:0] == cur_n_w[3:0])
    else $error("word address not aligned to block");
  a_sender_parity_fail_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    sender_parity_fail_rd && !cap_pf_i && sender_pf_i == 0 |=> sender_parity_fail_reg == 0 ##1
    !upf_reg[12])
    else $error("sender line not cleared by read");
  a_irq_route: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    stat_reg[0][BTE_ST_CMPL] |=> irq_unit_o[$past(ui0_w)])
    else $error("completion interrupt missing");
  a_bcast_new: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (upf_next & ~upf_reg) != 0 |=> pf_bcast_o)
    else $error("new unit fault not broadcast");
endmodule

// *** testbench/bte_xch_model.sv ***
// Purpose: exchange switch model answering engine requests
// Assumes: one request at a time, answered after a set delay
// Notes: answer data toggles whenever no read answer is due
`timescale 1ns/100ps
module bte_xch_model
  import bte_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire bte_xreq_s xreq_i,
  output bte_xrsp_s xrsp_o,
  input wire logic [3:0] delay_i,
  input wire logic pf_arm_i,
  input wire logic [7:0] salt_i,
  output logic rd_stb_o,
  output logic wr_stb_o,
  output logic [27:0] wr_addr_o,
  output logic [63:0] wr_data_o
);
  logic [3:0] wait_reg;
  // No second answer at the edge that takes the first
  wire logic take = xreq_i.valid && !xrsp_o.ack && wait_reg == 4'h0;
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i)
  begin
    xrsp_o.ack <= take;
    xrsp_o.pf <= take && pf_arm_i;
    rd_stb_o <= take && !xreq_i.write;
    wr_stb_o <= take && xreq_i.write;
    wr_addr_o <= xreq_i.addr;
    wr_data_o <= xreq_i.data;
    // Stale data must not pass for a fresh word
    if (take && !xreq_i.write)
      xrsp_o.data <= {salt_i, xreq_i.addr, ~xreq_i.addr};
    else
      xrsp_o.data <= ~xrsp_o.data;
    if (!rst_n_i || take)
      wait_reg <= delay_i;
    else if (xreq_i.valid && wait_reg != 4'h0)
      wait_reg <= wait_reg - 4'h1;
    if (!rst_n_i)
    begin
      xrsp_o.ack <= 1'h0;
      xrsp_o.pf <= 1'h0;
      rd_stb_o <= 1'h0;
      wr_stb_o <= 1'h0;
    end
  end
endmodule

// *** testbench/bte_top_tb.sv ***
// Purpose: self-checking bench for the block transfer engine
// Assumes: exchange model answers every request after a set delay
// Notes: expected words sit in a map keyed by destination address
`timescale 1ns/100ps
module bte_top_tb
  import bte_pkg::*;
;
  localparam logic [1:0] OK = BTE_OKAY;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [9:0] aw_addr = '0, ar_addr = '0;
  logic [31:0] w_data = '0, r_data;
  logic aw_valid = 1'h0, w_valid = 1'h0, b_ready = 1'h0;
  logic ar_valid = 1'h0, r_ready = 1'h0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [1:0] b_resp, r_resp;
  bte_xreq_s xreq;
  bte_xrsp_s xrsp;
  logic addr_pf = 1'h0, cap_pf = 1'h0, pf_bcast = 1'h0, pint_inh = 1'h0;
  logic [0:11] sender_pf = '0, unit_pf = '0;
  logic incoming_parity_fault, bcast_out, pf_arm = 1'h0, wr_stb, rd_stb;
  logic [15:0] irq_unit;
  logic [3:0] delay = '0, ui;
  logic [7:0] salt = 8'h3C;
  logic [27:0] wr_addr;
  logic [63:0] wr_data;
  logic [63:0] exp_wr [logic [27:0]];
  int ord[$];
  int error_cnt = 0, n_compared = 0, rd_cnt = 0, bc_cnt = 0;
  int seed = 32'hf39a;

  bte_top i_dut (.clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(aw_addr),
    .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready),
    .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_valid),
    .s_axi_wready_o(w_ready), .s_axi_bresp_o(b_resp),
    .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready),
    .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
    .s_axi_arready_o(ar_ready), .s_axi_rdata_o(r_data),
    .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_valid),
    .s_axi_rready_i(r_ready), .xreq_o(xreq), .xrsp_i(xrsp),
    .addr_pf_i(addr_pf), .sender_pf_i(sender_pf), .cap_pf_i(cap_pf),
    .unit_pf_i(unit_pf), .pf_bcast_i(pf_bcast), .pint_inhibit_i(pint_inh),
    .pfo_o(incoming_parity_fault), .pf_bcast_o(bcast_out), .irq_unit_o(irq_unit));
  bte_xch_model i_xch (.clk_i(clk), .rst_n_i(rst_n), .xreq_i(xreq),
    .xrsp_o(xrsp), .delay_i(delay), .pf_arm_i(pf_arm), .salt_i(salt),
    .rd_stb_o(rd_stb), .wr_stb_o(wr_stb), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge clk);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'h1;
    w_valid <= 1'h1;
    do @(posedge clk); while (aw_ready !== 1'h1 || w_ready !== 1'h1);
    aw_valid <= 1'h0;
    w_valid <= 1'h0;
    b_ready <= 1'h1;
    do @(posedge clk); while (b_valid !== 1'h1);
    b_ready <= 1'h0;
    chk(64'(b_resp), 64'(er));
  endtask

  task automatic axi_rd(input logic [9:0] a, output logic [31:0] d,
                        input logic [1:0] er);
    @(posedge clk);
    ar_addr <= a;
    ar_valid <= 1'h1;
    do @(posedge clk); while (ar_ready !== 1'h1);
    ar_valid <= 1'h0;
    r_ready <= 1'h1;
    do @(posedge clk); while (r_valid !== 1'h1);
    d = r_data;
    r_ready <= 1'h0;
    chk(64'(r_resp), 64'(er));
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] r;
    axi_rd(a, r, er);
    chk(64'(r), 64'(e));
  endtask

  // Model: last word first, block aligned to rounded size
  task automatic prog(input int c, input logic [27:0] s, input logic [27:0] d,
                      input int n, input logic [3:0] u);
    int m;
    logic [27:0] sa, da;
    m = 1;
    while (m < n + 1)
      m = m * 2;
    m = (m - 1) | 15;
    axi_wr(10'(c * 128), 32'(s), OK);
    axi_wr(10'(c * 128 + 4), 32'(d), OK);
    axi_wr(10'(c * 128 + 8), {12'h0, u, 16'(n)}, OK);
    // Built after time has passed, so a salt just driven is seen
    for (int k = n; k >= 0; k -= 2)
    begin
      sa = {s[27:24], (s[23:0] & ~24'(m)) | 24'(k)};
      da = {d[27:24], (d[23:0] & ~24'(m)) | 24'(k)};
      exp_wr[da] = (s[27:24] == 4'h9 && s[22]) ? '0 : {salt, sa, ~sa};
    end
  endtask

  task automatic wait_done(input int c, input logic [3:0] st);
    logic [31:0] r;
    do axi_rd(10'(c * 128 + 12), r, OK); while (r[3] === 1'h1);
    chk(64'(r), 64'(st));
  endtask
  ////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rd_stb === 1'h1)
      rd_cnt++;
    if (bcast_out === 1'h1)
      bc_cnt++;
    if (wr_stb === 1'h1)
    begin
      ord.push_back(int'(wr_addr[27:24]) - 1);
      if (exp_wr.exists(wr_addr))
      begin
        chk(wr_data, exp_wr[wr_addr]);
        exp_wr.delete(wr_addr);
      end
      else
        chk(64'(wr_addr), '1);
    end
  end

  initial
  begin
    forever #5 clk = ~clk;
  end

  // Generous span; the whole run needs under two thousand cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rd_chk(10'h00C, 32'h0, OK);
    rd_chk(10'h208, 32'h0, OK);
    rd_chk(10'h300, 32'h0, BTE_SLVERR);
    axi_wr(10'h300, 32'hFFFFFFFF, BTE_SLVERR);
    axi_wr(10'h208, 32'hF0, OK);
    rd_chk(10'h208, 32'h0, OK);
    // Single channel, misaligned random bases
    ui = 4'($random(seed));
    salt <= 8'($random(seed));
    delay <= 4'($random(seed)) & 4'h3;
    rd_cnt = 0;
    prog(1, {4'h1, 2'h0, 22'($random(seed))},
         {4'h2, 2'h0, 22'($random(seed))}, 18, ui);
    axi_wr(10'h08C, 32'h8, OK);
    wait_done(1, 4'h4);
    chk(exp_wr.num(), 0);
    chk(rd_cnt, 10);
    rd_chk(10'h088, {12'h0, ui, 16'hFFFE}, OK);
    chk(irq_unit[ui], 1);
    rd_chk(10'h208, 32'h40, OK);
    axi_wr(10'h08C, 32'h0, OK);
    repeat (2) @(posedge clk);
    chk(irq_unit[ui], 0);
    // Null transfer must issue no reads
    rd_cnt = 0;
    prog(2, {4'h9, 2'h1, 22'($random(seed))}, {4'h3, 24'h0}, 14, 4'h0);
    axi_wr(10'h10C, 32'h8, OK);
    wait_done(2, 4'h4);
    chk(rd_cnt, 0);
    chk(exp_wr.num(), 0);
    axi_wr(10'h10C, 32'h0, OK);
    // Slow exchange so all four start before the first word lands
    delay <= 4'hF;
    for (int c = 0; c < 4; c++)
      prog(c, {4'h1, 2'h0, 22'($random(seed))},
           {4'(c + 1), 24'(c * 4096)}, 6, 4'(c));
    ord.delete();
    for (int c = 0; c < 4; c++)
      axi_wr(10'(c * 128 + 12), 32'h8, OK);
    for (int c = 0; c < 4; c++)
      wait_done(c, 4'h4);
    chk(exp_wr.num(), 0);
    chk((1 << ord[0]) | (1 << ord[1]) | (1 << ord[2]) | (1 << ord[3]),
        15);
    rd_chk(10'h208, 32'hF0, OK);
    for (int c = 0; c < 4; c++)
      axi_wr(10'(c * 128 + 12), 32'h0, OK);
    // Parity fault on first answer aborts the channel
    delay <= 4'h1;
    pf_arm <= 1'h1;
    prog(3, {4'h1, 24'h0}, {4'h4, 24'h0}, 30, 4'h0);
    axi_wr(10'h18C, 32'h8, OK);
    wait_done(3, 4'h6);
    pf_arm <= 1'h0;
    exp_wr.delete();
    axi_wr(10'h18C, 32'h0, OK);
    // Software abort: clearing in-progress stops the block early
    prog(3, {4'h1, 24'h0}, {4'h4, 24'h0}, 30, 4'h0);
    axi_wr(10'h18C, 32'h8, OK);
    axi_wr(10'h18C, 32'h0, OK);
    repeat (200) @(posedge clk);
    rd_chk(10'h18C, 32'h0, OK);
    chk(exp_wr.num() != 0, 1);
    exp_wr.delete();
    // Incoming fault flag, cleared by reading
    addr_pf <= 1'h1;
    @(posedge clk);
    addr_pf <= 1'h0;
    repeat (2) @(posedge clk);
    chk(incoming_parity_fault, 1);
    rd_chk(10'h284, 32'h800, OK);
    rd_chk(10'h200, 32'h1, OK);
    rd_chk(10'h200, 32'h0, OK);
    chk(incoming_parity_fault, 0);
    // Sender and unit fault lines
    bc_cnt = 0;
    unit_pf[5] <= 1'h1;
    sender_pf[3] <= 1'h1;
    cap_pf <= 1'h1;
    @(posedge clk);
    sender_pf[3] <= 1'h0;
    cap_pf <= 1'h0;
    repeat (3) @(posedge clk);
    rd_chk(10'h284, 32'h1040, OK);
    chk(bc_cnt != 0, 1);
    rd_chk(10'h280, 32'h1100, OK);
    rd_chk(10'h284, 32'h0040, OK);
    rd_chk(10'h280, 32'h0, OK);
    unit_pf[5] <= 1'h0;
    repeat (2) @(posedge clk);
    rd_chk(10'h284, 32'h0, OK);
    // Request inhibit latched by a broadcast
    axi_wr(10'h204, 32'h1, OK);
    rd_chk(10'h204, 32'h1, OK);
    // Broadcast ignored while parity interrupts are inhibited
    pint_inh <= 1'h1;
    pf_bcast <= 1'h1;
    @(posedge clk);
    pf_bcast <= 1'h0;
    pint_inh <= 1'h0;
    rd_cnt = 0;
    prog(0, {4'h1, 24'h0}, {4'h6, 24'h0}, 2, 4'h0);
    axi_wr(10'h00C, 32'h8, OK);
    wait_done(0, 4'h4);
    chk(rd_cnt, 2);
    axi_wr(10'h00C, 32'h0, OK);
    pf_bcast <= 1'h1;
    @(posedge clk);
    pf_bcast <= 1'h0;
    rd_cnt = 0;
    prog(0, {4'h1, 24'h0}, {4'h5, 24'h0}, 2, 4'h0);
    axi_wr(10'h00C, 32'h8, OK);
    repeat (40) @(posedge clk);
    chk(rd_cnt, 0);
    axi_wr(10'h204, 32'h0, OK);
    wait_done(0, 4'h4);
    chk(exp_wr.num(), 0);
    give_verdict();
  end
endmodule
